//--- logic/dither_timestamp_link_ctrl.sv
// APB control bank for converter dither, sample timestamp marking and serial link gating
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dither_link_consts.svh"

// How it works
// RULE_01: Converter dither is applied only while the dither enable bit is set.
// RULE_02: The amplitude bit picks small dither at zero and large dither at one.
// RULE_03: The rounding bit sends subtraction error to the noise floor at zero, to offset and spurs at one.
// RULE_04: Software writes reset values into reserved fields.
// RULE_05: With timestamp insertion on, each output sample carries the timestamp on its LSB.
// RULE_06: The timestamp path latency matches the sample path latency.
// RULE_07: Software also enables timestamp reception whenever it enables insertion.
// RULE_08: A field wider than the converter gets the mark in its lowest bit, keeping the converter LSB.
// RULE_09: The lane alignment sequence always reports zero control bits.
// RULE_10: With the link enable clear, the link is held in reset, serializers off, clocks gated.
// RULE_11: With the link disabled, the multiframe counter is held in reset and ignores SYSREF.
// RULE_12: Software clears link enable before touching other link configuration.
// RULE_13: Calibration is enabled before the link and the link disabled before calibration.
// RULE_14: The six-bit mode field selects the transmitter output configuration.
// RULE_15: Software changes the mode only while link and calibration are both disabled.
// RULE_16: A new mode takes effect at the next link enable, never in a running link.
module dither_timestamp_link_ctrl
   import dither_link_pkg::*;
#(
   parameter int ADC_BITS = 9,
   parameter int FIELD_BITS = 12,
   parameter int ADDR_BITS = 12,
   parameter int LMFC_PERIOD = `LMFC_PERIOD_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_BITS-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timestamp_pin,
   input wire logic sysref_pin,
   input wire logic [ADC_BITS-1:0] adc_sample,
   input wire logic adc_sample_valid,
   output logic dither_enable,
   output logic dither_amplitude_select,
   output logic rounding_error_select,
   output logic timestamp_insert_enable,
   output logic timestamp_receive_enable,
   output logic calibration_enable,
   output logic link_enable,
   output logic link_reset_n,
   output logic serializer_power_down,
   output logic link_clock_enable,
   output logic lmfc_reset,
   output logic lmfc_boundary,
   output logic [5:0] active_output_mode,
   output logic [1:0] ila_control_bits,
   output logic [1:0] data_control_bits,
   output logic [FIELD_BITS-1:0] link_sample,
   output logic link_sample_valid
);
   localparam logic [ADDR_BITS-1:0] ADDR_DITHER = ADDR_BITS'(`IDX_DITHER_CONTROL * 4);
   localparam logic [ADDR_BITS-1:0] ADDR_LSB = ADDR_BITS'(`IDX_SAMPLE_LSB_CONTROL * 4);
   localparam logic [ADDR_BITS-1:0] ADDR_LINK_EN = ADDR_BITS'(`IDX_SERIAL_LINK_ENABLE * 4);
   localparam logic [ADDR_BITS-1:0] ADDR_MODE = ADDR_BITS'(`IDX_LINK_OUTPUT_MODE * 4);
   localparam logic [ADDR_BITS-1:0] ADDR_AUX = ADDR_BITS'(`IDX_AUX_CONTROL * 4);
   localparam int CNT_BITS = $clog2(LMFC_PERIOD);
   localparam logic [CNT_BITS-1:0] CNT_LAST = CNT_BITS'(LMFC_PERIOD - 1);

   reg8_type dither_control_r;
   reg8_type sample_lsb_control_r;
   reg8_type serial_link_enable_r;
   reg8_type link_output_mode_r;
   reg8_type aux_control_r;
   link_state_type link_state_r;
   link_state_type link_state_nxt;
   logic [CNT_BITS-1:0] lmfc_count_r;
   logic sysref_level;
   logic sysref_prev_r;
   logic timestamp_level;
   logic access;
   logic commit;
   logic wr_commit;
   logic mapped;
   reg8_type read_mux;
   logic link_on;

   // APB: access phase waits one cycle, so pready comes on the second access cycle
   assign access = psel && penable;
   assign commit = access && pready;
   assign wr_commit = commit && pwrite && pstrb[0] && !pslverr;

   always_comb
   begin
      mapped = 1'b1;
      read_mux = 8'h00;
      unique case (paddr)
         ADDR_DITHER: read_mux = dither_control_r;
         ADDR_LSB: read_mux = sample_lsb_control_r;
         ADDR_LINK_EN: read_mux = serial_link_enable_r;
         ADDR_MODE: read_mux = link_output_mode_r;
         ADDR_AUX: read_mux = aux_control_r;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (access && !pready)
      begin
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, read_mux};
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

   // Reserved bits are stored as written; keeping them at reset value is up to software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dither_control_r <= `RST_DITHER_CONTROL;
      end
      else if (wr_commit && paddr == ADDR_DITHER)
      begin
         dither_control_r <= pwdata[7:0]; // [RULE_04]
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sample_lsb_control_r <= `RST_SAMPLE_LSB_CONTROL;
      end
      else if (wr_commit && paddr == ADDR_LSB)
      begin
         sample_lsb_control_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serial_link_enable_r <= `RST_SERIAL_LINK_ENABLE;
      end
      else if (wr_commit && paddr == ADDR_LINK_EN)
      begin
         serial_link_enable_r <= pwdata[7:0];
      end
   end

   // Mode register is always writable; only the running copy is protected
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_output_mode_r <= `RST_LINK_OUTPUT_MODE;
      end
      else if (wr_commit && paddr == ADDR_MODE)
      begin
         link_output_mode_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aux_control_r <= `RST_AUX_CONTROL;
      end
      else if (wr_commit && paddr == ADDR_AUX)
      begin
         aux_control_r <= pwdata[7:0];
      end
   end

   // Converter-side controls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dither_enable <= 1'b0;
         dither_amplitude_select <= 1'b0;
         rounding_error_select <= 1'b0;
         timestamp_insert_enable <= 1'b0;
         timestamp_receive_enable <= 1'b0;
         calibration_enable <= 1'b0;
      end
      else
      begin
         dither_enable <= dither_control_r[`BIT_DITHER_ENABLE]; // [RULE_01]
         dither_amplitude_select <= dither_control_r[`BIT_DITHER_AMPLITUDE]; // [RULE_02]
         rounding_error_select <= dither_control_r[`BIT_ROUNDING_ERROR]; // [RULE_03]
         timestamp_insert_enable <= sample_lsb_control_r[`BIT_TIMESTAMP_INSERT]; // [RULE_05]
         timestamp_receive_enable <= aux_control_r[`BIT_TIMESTAMP_RECEIVE];
         calibration_enable <= aux_control_r[`BIT_CALIBRATION_ENABLE];
      end
   end

   // Link sequencing: OFF holds everything, START loads the mode, RUN transmits
   assign link_on = serial_link_enable_r[`BIT_LINK_ENABLE];

   always_comb
   begin
      link_state_nxt = link_state_r;
      unique case (link_state_r)
         LINK_OFF:
         begin
            if (link_on)
            begin
               link_state_nxt = LINK_START;
            end
         end
         LINK_START:
         begin
            link_state_nxt = link_on ? LINK_RUN : LINK_OFF;
         end
         LINK_RUN:
         begin
            if (!link_on)
            begin
               link_state_nxt = LINK_OFF;
            end
         end
         default: link_state_nxt = LINK_OFF;
      endcase
   end

   // Out of reset the link enable is set, so the link starts up on its own
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_state_r <= LINK_OFF;
      end
      else
      begin
         link_state_r <= link_state_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active_output_mode <= 6'(`RST_LINK_OUTPUT_MODE);
      end
      else if (link_state_r == LINK_START)
      begin
         active_output_mode <= link_output_mode_r[`MODE_FIELD_MSB:0]; // [RULE_14] [RULE_16]
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_enable <= 1'b0;
         link_reset_n <= 1'b0;
         serializer_power_down <= 1'b1;
         link_clock_enable <= 1'b0;
         lmfc_reset <= 1'b1;
      end
      else
      begin
         link_enable <= link_on;
         link_reset_n <= link_on && link_state_r == LINK_RUN; // [RULE_10]
         serializer_power_down <= !link_on; // [RULE_10]
         link_clock_enable <= link_on; // [RULE_10]
         // Enable bit checked too: state still reads RUN on the edge the bit drops
         lmfc_reset <= !link_on || link_state_r != LINK_RUN; // [RULE_11]
      end
   end

   pin_sync3 u_sysref_sync
   (
      .clk(pclk),
      .rst_n(presetn),
      .pin(sysref_pin),
      .level(sysref_level)
   );

   pin_sync3 u_timestamp_sync
   (
      .clk(pclk),
      .rst_n(presetn),
      .pin(timestamp_pin),
      .level(timestamp_level)
   );

   // Multiframe counter; SYSREF rising edge realigns it only while the link runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sysref_prev_r <= 1'b0;
         lmfc_count_r <= '0;
         lmfc_boundary <= 1'b0;
      end
      else
      begin
         sysref_prev_r <= sysref_level;
         if (link_state_r != LINK_RUN || !link_on)
         begin
            lmfc_count_r <= '0; // [RULE_11]
            lmfc_boundary <= 1'b0;
         end
         else if (sysref_level && !sysref_prev_r)
         begin
            lmfc_count_r <= '0;
            lmfc_boundary <= 1'b1;
         end
         else
         begin
            lmfc_count_r <= (lmfc_count_r == CNT_LAST) ? '0 : lmfc_count_r + 1'b1;
            lmfc_boundary <= lmfc_count_r == CNT_LAST;
         end
      end
   end

   // Control-bit counts: alignment sequence never advertises the mark
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ila_control_bits <= 2'h0;
         data_control_bits <= 2'h0;
      end
      else
      begin
         ila_control_bits <= 2'h0; // [RULE_09]
         data_control_bits <= {1'b0, sample_lsb_control_r[`BIT_TIMESTAMP_INSERT]};
      end
   end

   // Sample delay covers three sync flops plus the agreement register
   sample_lsb_insert #(
      .ADC_BITS(ADC_BITS),
      .FIELD_BITS(FIELD_BITS),
      .DELAY(`SYNC_STAGES + 1)
   ) u_insert
   (
      .clk(pclk),
      .rst_n(presetn),
      .sample(adc_sample),
      .sample_valid(adc_sample_valid),
      .mark(timestamp_level), // [RULE_06]
      .insert(timestamp_insert_enable), // [RULE_05] [RULE_08]
      .field(link_sample),
      .field_valid(link_sample_valid)
   );
endmodule
`default_nettype wire

//--- logic/dither_link_consts.svh
// Offsets, field positions, reset values and timing counts of the control bank
`ifndef DITHER_LINK_CONSTS_SVH
`define DITHER_LINK_CONSTS_SVH

// Printed register indices; byte address is four times the index
`define IDX_DITHER_CONTROL 12'h09d
`define IDX_SAMPLE_LSB_CONTROL 12'h160
`define IDX_SERIAL_LINK_ENABLE 12'h200
`define IDX_LINK_OUTPUT_MODE 12'h201
`define IDX_AUX_CONTROL 12'h3f0

`define RST_DITHER_CONTROL 8'h00
`define RST_SAMPLE_LSB_CONTROL 8'h00
`define RST_SERIAL_LINK_ENABLE 8'h01
`define RST_LINK_OUTPUT_MODE 8'h00
`define RST_AUX_CONTROL 8'h00

`define BIT_DITHER_ENABLE 0
`define BIT_DITHER_AMPLITUDE 1
`define BIT_ROUNDING_ERROR 2
`define BIT_TIMESTAMP_INSERT 0
`define BIT_LINK_ENABLE 0
`define BIT_CALIBRATION_ENABLE 0
`define BIT_TIMESTAMP_RECEIVE 1
`define MODE_FIELD_MSB 5
`define MODE_FIELD_WIDTH 6

`define SYNC_STAGES 3
`define LMFC_PERIOD_CYCLES 32

`endif

//--- logic/dither_link_pkg.sv
// Types imported by the control bank and its test bench
package dither_link_pkg;
   typedef logic [7:0] reg8_type;
   typedef logic [5:0] mode_type;
   typedef enum logic [1:0] {
      LINK_OFF = 2'b00,
      LINK_START = 2'b01,
      LINK_RUN = 2'b10
   } link_state_type;
endpackage

//--- logic/pin_sync3.sv
// Three-flop pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
         begin
            level <= s3_r;
         end
      end
   end
endmodule
`default_nettype wire

//--- logic/sample_lsb_insert.sv
// Delays converter samples to match the timestamp path and places the mark in the field LSB
`timescale 1ns/1ps
`default_nettype none
module sample_lsb_insert
#(
   parameter int ADC_BITS = 9,
   parameter int FIELD_BITS = 12,
   parameter int DELAY = 4
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADC_BITS-1:0] sample,
   input wire logic sample_valid,
   input wire logic mark,
   input wire logic insert,
   output logic [FIELD_BITS-1:0] field,
   output logic field_valid
);
   logic [ADC_BITS-1:0] pipe_r [DELAY];
   logic [DELAY-1:0] vpipe_r;
   logic [FIELD_BITS-1:0] aligned;

   // Sample delay equals the pin synchroniser latency, keeping marks on their samples
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vpipe_r <= '0;
         for (int i = 0; i < DELAY; i++)
         begin
            pipe_r[i] <= '0;
         end
      end
      else
      begin
         pipe_r[0] <= sample;
         vpipe_r[0] <= sample_valid;
         for (int i = 1; i < DELAY; i++)
         begin
            pipe_r[i] <= pipe_r[i-1];
            vpipe_r[i] <= vpipe_r[i-1];
         end
      end
   end

   generate
      if (FIELD_BITS > ADC_BITS)
      begin : g_wide
         // Converter LSB survives; mark goes in the padding below it
         always_comb
         begin
            aligned = {pipe_r[DELAY-1], {(FIELD_BITS-ADC_BITS){1'b0}}};
            if (insert)
            begin
               aligned[0] = mark;
            end
         end
      end
      else
      begin : g_equal
         always_comb
         begin
            aligned = pipe_r[DELAY-1];
            if (insert)
            begin
               aligned[0] = mark;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         field <= '0;
         field_valid <= 1'b0;
      end
      else
      begin
         field <= aligned;
         field_valid <= vpipe_r[DELAY-1];
      end
   end
endmodule
`default_nettype wire

//--- test/dither_link_ctrl_asserts.sv
// Port-level checker for the dither, timestamp and link control bank
`timescale 1ns/1ps
`default_nettype none
module dither_link_ctrl_asserts
#(
   parameter int ADC_BITS = 9,
   parameter int FIELD_BITS = 12,
   parameter int ADDR_BITS = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_BITS-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [ADC_BITS-1:0] adc_sample,
   input wire logic adc_sample_valid,
   input wire logic dither_enable,
   input wire logic dither_amplitude_select,
   input wire logic rounding_error_select,
   input wire logic timestamp_insert_enable,
   input wire logic link_enable,
   input wire logic link_reset_n,
   input wire logic serializer_power_down,
   input wire logic link_clock_enable,
   input wire logic lmfc_reset,
   input wire logic lmfc_boundary,
   input wire logic [5:0] active_output_mode,
   input wire logic [1:0] ila_control_bits,
   input wire logic [1:0] data_control_bits,
   input wire logic [FIELD_BITS-1:0] link_sample,
   input wire logic link_sample_valid
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pins follow one cycle after the write edge, so look two edges on
   sequence dither_write;
      psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h274;
   endsequence
   chk_dither_write: assert property (dither_write |-> ##2 (dither_enable == $past(pwdata[0], 2) &&
      dither_amplitude_select == $past(pwdata[1], 2) && rounding_error_select == $past(pwdata[2], 2)))
      else $error("dither pins do not follow the write");
   chk_ila_zero: assert property (ila_control_bits == 2'h0) else $error("ila control bits not zero");
   chk_ctrl_bits: assert property ($stable(timestamp_insert_enable) |-> data_control_bits == {1'b0, timestamp_insert_enable})
      else $error("data control bits wrong");
   chk_link_off: assert property (!link_enable |-> serializer_power_down && !link_clock_enable && !link_reset_n)
      else $error("link not held off");
   chk_lmfc_hold: assert property (!link_enable |-> lmfc_reset && !lmfc_boundary)
      else $error("lmfc counter not held");
   chk_mode_hold: assert property (link_reset_n && $past(link_reset_n) |-> $stable(active_output_mode))
      else $error("mode changed while running");
   chk_sample_lat: assert property (link_sample_valid == $past(adc_sample_valid, 5))
      else $error("sample latency wrong");
   chk_sample_pos: assert property (link_sample_valid |-> link_sample[FIELD_BITS-1 -: ADC_BITS] == $past(adc_sample, 5)
      && link_sample[FIELD_BITS-ADC_BITS-1:1] == '0) else $error("sample placement wrong");
   chk_insert_off: assert property (link_sample_valid && !timestamp_insert_enable &&
      !$past(timestamp_insert_enable) |-> !link_sample[0]) else $error("mark present with insertion off");
   chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state count wrong");
   cover property (!link_enable ##1 link_enable);
   cover property (link_sample_valid && link_sample[0]);
   cover property (lmfc_boundary);
endmodule
bind dither_timestamp_link_ctrl dither_link_ctrl_asserts #(.ADC_BITS(ADC_BITS), .FIELD_BITS(FIELD_BITS),
   .ADDR_BITS(ADDR_BITS)) dither_link_ctrl_asserts_i (.*);
`default_nettype wire

//--- test/dither_timestamp_link_ctrl_test.sv
// Self-checking bench for the dither, timestamp and link control bank
`timescale 1ns/1ps
`default_nettype none
module dither_timestamp_link_ctrl_test;
   import dither_link_pkg::*;
   localparam int LMFC = 16;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_type;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timestamp_pin, sysref_pin, adc_sample_valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [8:0] adc_sample;
   logic dither_enable, dither_amplitude_select, rounding_error_select, timestamp_insert_enable;
   logic timestamp_receive_enable, calibration_enable, link_enable, link_reset_n, serializer_power_down;
   logic link_clock_enable, lmfc_reset, lmfc_boundary, link_sample_valid, er;
   logic [5:0] active_output_mode;
   logic [1:0] ila_control_bits, data_control_bits;
   logic [11:0] link_sample;
   int error_cnt = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;
   row_type rows [8] = '{
      '{12'h274, 32'h07, 32'h07, 1'b0}, '{12'h274, 32'h02, 32'h02, 1'b0}, '{12'h804, 32'h3f, 32'h3f, 1'b0},
      '{12'hfc0, 32'h03, 32'h03, 1'b0}, '{12'h580, 32'hffffff01, 32'h01, 1'b0}, '{12'h580, 32'h00, 32'h00, 1'b0},
      '{12'h004, 32'hff, 32'h00, 1'b1}, '{12'hffc, 32'h55, 32'h00, 1'b1}};
   dither_timestamp_link_ctrl #(.LMFC_PERIOD(LMFC)) dither_timestamp_link_ctrl_i (.*);
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // Holds the request until pready is sampled high, then idles one cycle
   task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
      psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic send(input logic [8:0] s, input logic [11:0] exp);
      adc_sample <= s; adc_sample_valid <= 1'b1;
      @(posedge pclk);
      adc_sample_valid <= 1'b0;
      while (link_sample_valid !== 1'b1) @(posedge pclk);
      check("link_sample", exp, link_sample);
   endtask
   initial
   begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      pstrb = 4'hf; timestamp_pin = 1'b0; sysref_pin = 1'b0; adc_sample = 9'h000; adc_sample_valid = 1'b0;
      tick(6);
      presetn <= 1'b1;
      tick(4);
      // Link off before any other link configuration is touched
      apb(12'h800, 32'h00, 1'b1, 4'hf);
      foreach (rows[i])
      begin
         apb(rows[i].a, rows[i].d, 1'b1, 4'hf);
         check("write error", rows[i].e, er);
         apb(rows[i].a, 32'h0, 1'b0, 4'hf);
         check("read data", rows[i].r, rd);
         check("read error", rows[i].e, er);
      end
      $display("register table done");
      // Dither pin decoding, and a write with lane 0 off is dropped
      apb(12'h274, 32'h05, 1'b1, 4'hf);
      tick(2);
      check("dither pins", 32'h5, {rounding_error_select, dither_amplitude_select, dither_enable});
      apb(12'h274, 32'h02, 1'b1, 4'hf);
      apb(12'h274, 32'h07, 1'b1, 4'he);
      tick(2);
      check("dither pins", 32'h2, {rounding_error_select, dither_amplitude_select, dither_enable});
      check("aux pins", 32'h3, {timestamp_receive_enable, calibration_enable});
      $display("dither done");
      // Mode written while the link is off stays out until the next start
      check("active mode", 32'h00, active_output_mode);
      apb(12'h800, 32'h00, 1'b1, 4'hf);
      tick(3);
      check("link off", 32'h9, {serializer_power_down, link_clock_enable, link_reset_n, lmfc_reset});
      sysref_pin <= 1'b1;
      tick(8);
      check("lmfc held", 32'h1, {lmfc_boundary, lmfc_reset});
      sysref_pin <= 1'b0;
      apb(12'hfc0, 32'h00, 1'b1, 4'hf);
      apb(12'h804, 32'h15, 1'b1, 4'hf);
      apb(12'hfc0, 32'h03, 1'b1, 4'hf);
      apb(12'h800, 32'h01, 1'b1, 4'hf);
      tick(4);
      check("active mode", 32'h15, active_output_mode);
      check("link on", 32'h6, {serializer_power_down, link_clock_enable, link_reset_n, lmfc_reset});
      while (lmfc_boundary !== 1'b1) @(posedge pclk);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (lmfc_boundary !== 1'b1);
      check("lmfc period", LMFC, n);
      $display("link done");
      // Timestamp marking in the field LSB
      apb(12'h800, 32'h00, 1'b1, 4'hf);
      timestamp_pin <= 1'b1;
      apb(12'h580, 32'h01, 1'b1, 4'hf);
      tick(8);
      check("data control bits", 32'h1, data_control_bits);
      check("ila control bits", 32'h0, ila_control_bits);
      send(9'h001, 12'h009);
      send(9'h1a5, 12'hd29);
      timestamp_pin <= 1'b0;
      tick(8);
      send(9'h1a5, 12'hd28);
      // Pin and sample change together: the mark must land on this very sample
      timestamp_pin <= 1'b1;
      send(9'h0f0, 12'h781);
      apb(12'h580, 32'h00, 1'b1, 4'hf);
      tick(8);
      send(9'h0ff, 12'h7f8);
      $display("timestamp done");
      // Mid-run reset brings back the reset values
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      tick(4);
      apb(12'h800, 32'h0, 1'b0, 4'hf);
      check("link enable reset", 32'h01, rd);
      apb(12'h804, 32'h0, 1'b0, 4'hf);
      check("mode reset", 32'h00, rd);
      apb(12'h274, 32'h0, 1'b0, 4'hf);
      check("dither reset", 32'h00, rd);
      check("active mode reset", 32'h00, active_output_mode);
      $display("reset done");
      finish_test();
   end
endmodule
`default_nettype wire
